// [hdl/rtc_pkg.sv]
// rtc_pkg: register map, field positions, reset values and timing constants
// assumes a 40 MHz ref_clk and a 32.768 kHz crystal sampled as a plain input
package rtc_pkg;
  localparam int REF_CLK_HZ = 40_000_000;
  localparam int BUS_RATE_BPS = 400_000;
  // ref_clk cycles in half a bit period at the top bus rate
  localparam int SCL_HALF_CYCLES = REF_CLK_HZ / (2 * BUS_RATE_BPS);
  localparam int XTAL_HZ = 32_768;

  localparam int REG_COUNT = 18;
  localparam logic [4:0] PTR_FIRST = 5'h00;
  localparam logic [4:0] PTR_LAST = 5'h11;
  localparam logic [4:0] ADDR_CTRL1 = 5'h00;
  localparam logic [4:0] ADDR_CTRL2 = 5'h01;
  localparam logic [4:0] ADDR_OFFSET = 5'h02;
  localparam logic [4:0] ADDR_SCRATCH = 5'h03;
  localparam logic [4:0] ADDR_SECONDS = 5'h04;
  localparam logic [4:0] ADDR_YEARS = 5'h0A;
  localparam logic [4:0] ADDR_ALARM_FIRST = 5'h0B;
  localparam logic [4:0] ADDR_ALARM_LAST = 5'h0F;
  localparam logic [4:0] ADDR_TIMER_VALUE = 5'h10;
  localparam logic [4:0] ADDR_TIMER_MODE = 5'h11;
  localparam int TIME_BASE = 4;
  localparam int TIME_FIELDS = 7;

  localparam int CTRL1_STOP_BIT = 5;
  localparam int CTRL1_SRST_BIT = 4;
  localparam int CTRL2_MIN_IRQ_BIT = 5;
  localparam int CTRL2_HALF_IRQ_BIT = 4;
  localparam int CTRL2_FLAG_BIT = 3;
  localparam int COF_MSB = 2;

  // implemented bits per register; soft reset bit holds no state
  localparam logic [7:0] REG_MASK [REG_COUNT] = '{
    8'hA7, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h3F, 8'h3F, 8'h07,
    8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hBF, 8'hBF, 8'h87, 8'hFF, 8'h1F};
  localparam logic [7:0] REG_RESET [REG_COUNT] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00,
    8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // counting bits of each time field, seconds first
  localparam logic [7:0] FIELD_MASK [TIME_FIELDS] = '{
    8'h7F, 8'h7F, 8'h3F, 8'h3F, 8'h07, 8'h1F, 8'hFF};

  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] BCD_HALF_LAST = 8'h29;
  localparam logic [7:0] BCD_SEC_LAST = 8'h59;
  localparam logic [7:0] BCD_HOUR_LAST = 8'h23;
  localparam logic [7:0] BCD_WDAY_LAST = 8'h06;
  localparam logic [7:0] BCD_MONTH_LAST = 8'h12;
  localparam logic [7:0] BCD_YEAR_LAST = 8'h99;
  localparam logic [7:0] BCD_FEB = 8'h02;
  localparam logic [7:0] BCD_APR = 8'h04;
  localparam logic [7:0] BCD_JUN = 8'h06;
  localparam logic [7:0] BCD_SEP = 8'h09;
  localparam logic [7:0] BCD_NOV = 8'h11;
  localparam logic [7:0] BCD_D28 = 8'h28;
  localparam logic [7:0] BCD_D29 = 8'h29;
  localparam logic [7:0] BCD_D30 = 8'h30;
  localparam logic [7:0] BCD_D31 = 8'h31;

  localparam int DIV_WIDTH = 15;
  localparam logic [14:0] DIV_LAST = 15'h7FFF;
  localparam logic [2:0] COF_XTAL = 3'h0;
  localparam logic [2:0] COF_1HZ = 3'h6;
  localparam logic [2:0] COF_OFF = 3'h7;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef struct packed {
    logic en;
    logic [4:0] idx;
    logic [7:0] data;
  } rtc_wr_t;
endpackage : rtc_pkg

// [hdl/rtc_bcd_step.sv]
// rtc_bcd_step: one bcd counter stage with wrap from hi back to lo
// assumes value is a legal bcd number; purely combinational
`timescale 1ns/1ps
module rtc_bcd_step (
  // counter stage
  input wire logic [7:0] value,
  input wire logic [7:0] lo,
  input wire logic [7:0] hi,
  input wire logic carry_in,
  output logic [7:0] next_value,
  output logic carry_out
);
  always_comb begin
    carry_out = carry_in && (value >= hi);
    if (!carry_in) begin
      next_value = value;
    end else if (value >= hi) begin
      next_value = lo;
    end else if (value[3:0] >= 4'h9) begin
      next_value = {value[7:4] + 4'h1, 4'h0};
    end else begin
      next_value = {value[7:4], value[3:0] + 4'h1};
    end
  end
endmodule : rtc_bcd_step

// [hdl/rtc_core.sv]
// rtc_core: two-wire register target, bcd calendar, divider, clock out, irq
// assumes scl, sda, xtal and the enable pin are synchronous to ref_clk
// Functional notes
// - eighteen byte registers behind one pointer
// - pointer advances per byte, wraps 11h to 00h
// - bus runs up to 400 kbit/s
// - every register a full byte, holes hold nothing
// - control registers at 00h and 01h
// - frequency offset register at 02h
// - free scratch byte at 03h
// - seconds to years at 04h to 0Ah
// - alarm registers at 0Bh to 0Fh
// - timer registers at 10h and 11h
// - time and alarm values kept in bcd
// - time counters frozen during bus access
// - time base divided from crystal
// - count seconds through years from crystal
// - selectable clock output frequencies
// - clock output follows enable pin
// - minute or half-minute interrupt
// - stop bit halts and clears divider
// - soft reset bit resets, reads zero
`timescale 1ns/1ps
module rtc_core
  import rtc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // arbitrary target address
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // crystal time base
  input wire logic xtal_in,
  // clock output
  input wire logic clock_output_enable_pin,
  output logic programmable_clock_output,
  // open-drain interrupt
  output logic int_out,
  output logic int_oe
);
  if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF) begin : bad_addr
    $error("DEV_ADDR falls in a reserved bus address range");
  end
  if (SCL_HALF_CYCLES < 4) begin : bad_rate
    $error("ref_clk too slow to sample the bus");
  end

  typedef enum {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR,
    ST_WDATA, ST_ACK_WDATA, ST_RDATA, ST_ACK_RDATA
  } rtc_state_t;

  rtc_state_t state;
  logic [7:0] regs [REG_COUNT];
  logic [4:0] ptr;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] tx_sr;
  logic rw_read;
  logic master_nack;
  rtc_wr_t wr;
  logic soft_rst;
  logic scl_q, sda_q, xtal_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [7:0] rd_byte;
  logic [4:0] next_ptr;
  logic bus_busy;
  logic [DIV_WIDTH-1:0] div;
  logic xtal_rise, stopped, second_tick, pending_tick, time_step;
  logic irq_event;
  logic cof_sel;
  logic [7:0] field_val [TIME_FIELDS];
  logic [7:0] field_lo [TIME_FIELDS];
  logic [7:0] field_hi [TIME_FIELDS];
  logic [7:0] field_next [TIME_FIELDS];
  logic field_cin [TIME_FIELDS];
  logic field_cout [TIME_FIELDS];
  logic leap_year;
  logic [7:0] month_days;

  // pin sampling and bus conditions; 40 MHz oversamples a 400 kbit/s bus
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      xtal_q <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      xtal_q <= xtal_in;
    end
  end
  assign scl_rise = scl_in && !scl_q;
  assign scl_fall = !scl_in && scl_q;
  assign bus_start = scl_in && scl_q && sda_q && !sda_in;
  assign bus_stop = scl_in && scl_q && !sda_q && sda_in;

  // one pointer for all eighteen registers, wrapping after the last
  assign next_ptr = (ptr == PTR_LAST) ? PTR_FIRST : ptr + 5'h01;
  // full-byte read, holes and the soft reset bit read zero
  assign rd_byte = regs[ptr] & REG_MASK[ptr];
  assign bus_busy = (state != ST_IDLE);

  // bus target state machine
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      ptr <= PTR_FIRST;
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
      tx_sr <= 8'hFF;
      rw_read <= 1'b0;
      master_nack <= 1'b0;
      wr <= '0;
    end else begin
      wr.en <= 1'b0;
      if (bus_start) begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
      end else if (bus_stop) begin
        state <= ST_IDLE;
      end else if (scl_rise) begin
        case (state)
          ST_ADDR, ST_PTR, ST_WDATA: begin
            shift_in <= {shift_in[6:0], sda_in};
            bit_cnt <= bit_cnt + 4'h1;
          end
          ST_RDATA: bit_cnt <= bit_cnt + 4'h1;
          ST_ACK_RDATA: master_nack <= sda_in;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (bit_cnt == BITS_PER_BYTE) begin
              bit_cnt <= 4'h0;
              rw_read <= shift_in[0];
              state <= (shift_in[7:1] == DEV_ADDR) ? ST_ACK_ADDR : ST_IDLE;
            end
          end
          ST_ACK_ADDR: begin
            bit_cnt <= 4'h0;
            if (rw_read) begin
              tx_sr <= rd_byte;
              state <= ST_RDATA;
            end else begin
              state <= ST_PTR;
            end
          end
          ST_PTR: begin
            if (bit_cnt == BITS_PER_BYTE) begin
              // out-of-map pointer values start at 00h
              ptr <= (shift_in[4:0] > PTR_LAST || shift_in[7:5] != 3'h0) ?
                     PTR_FIRST : shift_in[4:0];
              state <= ST_ACK_PTR;
            end
          end
          ST_ACK_PTR: begin
            bit_cnt <= 4'h0;
            state <= ST_WDATA;
          end
          ST_WDATA: begin
            if (bit_cnt == BITS_PER_BYTE) begin
              wr.en <= 1'b1;
              wr.idx <= ptr;
              wr.data <= shift_in;
              ptr <= next_ptr;
              state <= ST_ACK_WDATA;
            end
          end
          ST_ACK_WDATA: begin
            bit_cnt <= 4'h0;
            state <= ST_WDATA;
          end
          ST_RDATA: begin
            if (bit_cnt == BITS_PER_BYTE) begin
              ptr <= next_ptr;
              state <= ST_ACK_RDATA;
            end else begin
              tx_sr <= {tx_sr[6:0], 1'b1};
            end
          end
          ST_ACK_RDATA: begin
            bit_cnt <= 4'h0;
            if (master_nack) begin
              state <= ST_IDLE;
            end else begin
              tx_sr <= rd_byte;
              state <= ST_RDATA;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // open-drain data line: pull low for acks and zero read bits
  assign sda_out = 1'b0;
  always_comb begin
    case (state)
      ST_ACK_ADDR, ST_ACK_PTR, ST_ACK_WDATA: sda_oe = 1'b1;
      ST_RDATA: sda_oe = !tx_sr[7];
      default: sda_oe = 1'b0;
    endcase
  end

  // soft reset pulse from a write of one to the reset bit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr.en && wr.idx == ADDR_CTRL1 && wr.data[CTRL1_SRST_BIT];
    end
  end

  // crystal divider; stop holds every stage at zero
  assign stopped = regs[ADDR_CTRL1][CTRL1_STOP_BIT];
  assign xtal_rise = xtal_in && !xtal_q;
  always_ff @(posedge ref_clk) begin
    if (rst || soft_rst || stopped) begin
      div <= '0;
    end else if (xtal_rise) begin
      div <= div + 15'h0001;
    end
  end
  assign second_tick = xtal_rise && !stopped && div == DIV_LAST;

  // a second arriving mid-access waits until the bus goes idle
  always_ff @(posedge ref_clk) begin
    if (rst || soft_rst) begin
      pending_tick <= 1'b0;
    end else if (second_tick) begin
      pending_tick <= 1'b1;
    end else if (time_step) begin
      pending_tick <= 1'b0;
    end
  end
  assign time_step = pending_tick && !bus_busy && !stopped;

  // calendar chain: sec, min, hour, day, weekday, month, year
  assign leap_year = regs[ADDR_YEARS][4] ?
                     (regs[ADDR_YEARS][3:0] == 4'h2 || regs[ADDR_YEARS][3:0] == 4'h6) :
                     (regs[ADDR_YEARS][3:0] == 4'h0 || regs[ADDR_YEARS][3:0] == 4'h4 ||
                      regs[ADDR_YEARS][3:0] == 4'h8);
  always_comb begin
    case (field_val[5])
      BCD_FEB: month_days = leap_year ? BCD_D29 : BCD_D28;
      BCD_APR, BCD_JUN, BCD_SEP, BCD_NOV: month_days = BCD_D30;
      default: month_days = BCD_D31;
    endcase
  end
  always_comb begin
    field_lo = '{BCD_ZERO, BCD_ZERO, BCD_ZERO, BCD_ONE, BCD_ZERO, BCD_ONE, BCD_ZERO};
    field_hi = '{BCD_SEC_LAST, BCD_SEC_LAST, BCD_HOUR_LAST, month_days,
                 BCD_WDAY_LAST, BCD_MONTH_LAST, BCD_YEAR_LAST};
    field_cin[0] = time_step;
    field_cin[1] = field_cout[0];
    field_cin[2] = field_cout[1];
    field_cin[3] = field_cout[2];
    field_cin[4] = field_cout[2];
    field_cin[5] = field_cout[3];
    field_cin[6] = field_cout[5];
  end
  for (genvar k = 0; k < TIME_FIELDS; k++) begin : g_field
    assign field_val[k] = regs[TIME_BASE + k] & FIELD_MASK[k];
    rtc_bcd_step u_step (
      .value(field_val[k]),
      .lo(field_lo[k]),
      .hi(field_hi[k]),
      .carry_in(field_cin[k]),
      .next_value(field_next[k]),
      .carry_out(field_cout[k])
    );
  end

  // minute and half-minute events
  assign irq_event = time_step && (
    (regs[ADDR_CTRL2][CTRL2_MIN_IRQ_BIT] && field_val[0] == BCD_SEC_LAST) ||
    (regs[ADDR_CTRL2][CTRL2_HALF_IRQ_BIT] &&
     (field_val[0] == BCD_SEC_LAST || field_val[0] == BCD_HALF_LAST)));

  // register file; map 00h-11h covers control, offset, scratch, time, alarm, timer
  always_ff @(posedge ref_clk) begin
    if (rst || soft_rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= REG_RESET[i];
      end
    end else begin
      if (wr.en) begin
        regs[wr.idx] <= wr.data & REG_MASK[wr.idx];
      end
      for (int k = 0; k < TIME_FIELDS; k++) begin
        if (time_step) begin
          regs[TIME_BASE + k] <= (regs[TIME_BASE + k] & ~FIELD_MASK[k]) |
                                 field_next[k];
        end
      end
      if (irq_event) begin
        regs[ADDR_CTRL2][CTRL2_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // clock output select and gate
  always_comb begin
    case (regs[ADDR_CTRL2][COF_MSB:0])
      COF_XTAL: cof_sel = xtal_q;
      3'h1: cof_sel = div[0];
      3'h2: cof_sel = div[1];
      3'h3: cof_sel = div[2];
      3'h4: cof_sel = div[3];
      3'h5: cof_sel = div[4];
      COF_1HZ: cof_sel = div[DIV_WIDTH-1];
      COF_OFF: cof_sel = 1'b0;
      default: cof_sel = 1'b0;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      programmable_clock_output <= 1'b0;
      int_oe <= 1'b0;
    end else begin
      programmable_clock_output <= clock_output_enable_pin && cof_sel;
      int_oe <= regs[ADDR_CTRL2][CTRL2_FLAG_BIT] &&
                (regs[ADDR_CTRL2][CTRL2_MIN_IRQ_BIT] ||
                 regs[ADDR_CTRL2][CTRL2_HALF_IRQ_BIT]);
    end
  end
  assign int_out = 1'b0;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  ptr_in_map_a: assert property (ptr <= PTR_LAST)
    else $error("register pointer left the map");
  ptr_wrap_a: assert property ((state == ST_RDATA && scl_fall && !bus_start &&
    !bus_stop && bit_cnt == BITS_PER_BYTE && ptr == PTR_LAST) |=> ptr == PTR_FIRST)
    else $error("pointer did not wrap to zero");
  ptr_step_a: assert property ((state == ST_WDATA && scl_fall && !bus_start &&
    !bus_stop && bit_cnt == BITS_PER_BYTE && ptr != PTR_LAST) |=> ptr == $past(ptr) + 5'h01)
    else $error("pointer did not advance by one");
  time_frozen_a: assert property ((bus_busy && !wr.en && !soft_rst) |=>
    $stable(regs[ADDR_SECONDS]))
    else $error("seconds moved during bus access");
  sec_bcd_a: assert property (regs[ADDR_SECONDS][3:0] <= 4'h9 &&
    regs[ADDR_SECONDS][6:4] <= 3'h5)
    else $error("seconds not bcd");
  stop_clear_a: assert property (stopped |=> div == '0)
    else $error("divider not cleared while stopped");
  srst_effect_a: assert property ((wr.en && wr.idx == ADDR_CTRL1 &&
    wr.data[CTRL1_SRST_BIT]) |=> soft_rst ##1 regs[ADDR_CTRL1] == REG_RESET[0])
    else $error("soft reset did not restore control");
  srst_reads_a: assert property (!regs[ADDR_CTRL1][CTRL1_SRST_BIT])
    else $error("soft reset bit held state");
  holes_empty_a: assert property ((regs[ptr] & ~REG_MASK[ptr]) == 8'h00)
    else $error("unimplemented bit holds state");
  programmable_clock_output_gate_a: assert property (!clock_output_enable_pin |=> !programmable_clock_output)
    else $error("clock output active while disabled");
  minute_irq_a: assert property ((time_step && field_val[0] == BCD_SEC_LAST &&
    regs[ADDR_CTRL2][CTRL2_MIN_IRQ_BIT] && !soft_rst) |=> ##1 int_oe)
    else $error("minute interrupt not raised");
endmodule : rtc_core

// [bench/rtc_i2c_host.sv]
// rtc_i2c_host: two-wire bus controller model, drives scl, pulls sda low
// assumes the bench resolves sda with a pull-up from all pull-downs
`timescale 1ns/1ps
module rtc_i2c_host
  import rtc_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // bus
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  localparam int H = SCL_HALF_CYCLES;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  // one bit; data only moves while scl is low
  task automatic xfer(input logic b, output logic r);
    tick(5);
    sda_pull = ~b;
    tick(H - 5);
    scl = 1'b1;
    tick(H / 2);
    r = sda;
    tick(H / 2);
    scl = 1'b0;
  endtask : xfer

  task automatic start();
    tick(5);
    sda_pull = 1'b0;
    tick(H - 5);
    scl = 1'b1;
    tick(H / 2);
    sda_pull = 1'b1;
    tick(H / 2);
    scl = 1'b0;
  endtask : start

  task automatic stop();
    tick(5);
    sda_pull = 1'b1;
    tick(H - 5);
    scl = 1'b1;
    tick(H / 2);
    sda_pull = 1'b0;
    tick(H / 2);
  endtask : stop

  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(d[i], r);
    xfer(1'b1, r);
    ack = ~r;
  endtask : put

  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, r);
      d[i] = r;
    end
    xfer(last, r);
  endtask : get
endmodule : rtc_i2c_host

// [bench/rtc_register_access_tb.sv]
// rtc_register_access_tb: register map, pointer, calendar and clock out checks
// assumes rtc_core and the rtc_i2c_host model; xtal is driven fast
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module rtc_register_access_tb
  import rtc_pkg::*;
;
  localparam logic [6:0] ADDR = 7'h2A; // arbitrary target address
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic xtal = 1'b0;
  logic en = 1'b1;
  logic mon_on = 1'b0;
  logic [2:0] cof_mode = 3'h0;
  logic scl, pull, sda_oe, clk_out, int_oe, px, px2, pen;
  wire logic sda = ~(pull | sda_oe);
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  int mptr;
  logic [7:0] mreg [REG_COUNT];

  rtc_core #(.DEV_ADDR(ADDR)) DUT (.ref_clk(ref_clk), .rst(rst), .scl_in(scl),
    .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .xtal_in(xtal),
    .clock_output_enable_pin(en), .programmable_clock_output(clk_out),
    .int_out(), .int_oe(int_oe));
  rtc_i2c_host HOST (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_pull(pull));

  always #12.5 ref_clk = ~ref_clk;

  // clock output: crystal seen two edges back (input stage), enable one edge back
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (mon_on) `CHK("clk out", (cof_mode == 3'h0) ? (px2 & pen) : 1'b0, clk_out)
    px <= xtal;
    px2 <= px;
    pen <= en;
    if (cyc == 120000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic m_reset();
    for (int i = 0; i < REG_COUNT; i++) mreg[i] = REG_RESET[i];
  endtask : m_reset

  task automatic open(input logic [7:0] p);
    logic a;
    HOST.start();
    HOST.put({ADDR, 1'b0}, a);
    `CHK("addr ack", 1'b1, a)
    HOST.put(p, a);
    `CHK("ptr ack", 1'b1, a)
    mptr = (p > 8'h11) ? 0 : int'(p);
  endtask : open

  task automatic wr(input logic [7:0] p, input logic [7:0] d [$]);
    logic a;
    open(p);
    foreach (d[i]) begin
      HOST.put(d[i], a);
      `CHK("data ack", 1'b1, a)
      mreg[mptr] = d[i] & REG_MASK[mptr];
      if (mptr == 0 && d[i][CTRL1_SRST_BIT]) m_reset();
      mptr = (mptr == 17) ? 0 : mptr + 1;
    end
    HOST.stop();
  endtask : wr

  task automatic rd_more(input int n);
    logic [7:0] v;
    logic a;
    HOST.start();
    HOST.put({ADDR, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      HOST.get(i == n - 1, v);
      `CHK($sformatf("reg %0h", mptr), mreg[mptr], v)
      mptr = (mptr == 17) ? 0 : mptr + 1;
    end
    HOST.stop();
  endtask : rd_more

  // 20 MHz crystal stand-in, one rise per two edges keeps the run short
  task automatic run_xtal(input int n);
    for (int i = 0; i < n; i++) begin
      if (i % 4096 == 0) en = 1'($urandom());
      xtal = 1'b1;
      @(posedge ref_clk);
      #1 xtal = 1'b0;
      @(posedge ref_clk);
      #1;
    end
  endtask : run_xtal

  initial begin
    logic [7:0] q [$];
    logic a;
    void'($urandom(32'hC57E0778));
    m_reset();
    repeat (10) @(posedge ref_clk);
    #1 rst = 1'b0;
    // random control, offset and scratch; soft reset restores them
    for (int i = 0; i < 4; i++) q.push_back(8'($urandom()));
    q[0] &= 8'h4F;
    q[1] &= 8'hF7;
    wr(8'h00, q);
    wr(8'h00, '{8'h10});
    open(8'h00);
    rd_more(4);
    // divider runs to the edge of a second while the map is exercised
    fork
      run_xtal(32767);
      begin
        // reset values, full map and wrap
        open(8'h00);
        rd_more(19);
        HOST.start();
        HOST.put({ADDR ^ 7'h01, 1'b0}, a);
        `CHK("foreign addr", 1'b0, a)
        HOST.stop();
        // random burst wrapping through 11h to 00h
        q.delete();
        for (int i = 0; i < 8; i++) q.push_back(8'($urandom()));
        q[4] &= 8'h4F;
        q[5] &= 8'hF7;
        wr(8'h0E, q);
        open(8'h0E);
        rd_more(8);
        open(8'hA3);
        rd_more(1);
        `CHK("irq idle", 1'b0, int_oe)
        // calendar at end of february, minute irq enabled
        wr(8'h01, '{8'h20, 8'h00, 8'($urandom()), 8'h59, 8'h59, 8'h23, 8'h28,
          8'h06, 8'h02, 8'h23});
        mon_on = 1'b1;
      end
    join
    open(8'h04);
    run_xtal(1);
    rd_more(1);
    mreg[1] = 8'h28;
    for (int i = 4; i < 10; i++) mreg[i] = 8'h00;
    mreg[7] = 8'h01;
    mreg[9] = 8'h03;
    open(8'h01);
    rd_more(10);
    `CHK("irq set", 1'b1, int_oe)
    // divider stopped, flag cleared with minute irq kept, clock output off
    mon_on = 1'b0;
    wr(8'h00, '{8'h20, 8'h27});
    cof_mode = 3'h7;
    mon_on = 1'b1;
    run_xtal(16);
    `CHK("irq clear", 1'b0, int_oe)
    wrap_up();
  end
endmodule : rtc_register_access_tb
